/* rtl/itf_params.svh */
`ifndef ITF_PARAMS_SVH
`define ITF_PARAMS_SVH

// clock and filter timing
`define ITF_CLK_HZ        50000000
`define ITF_MS_PER_S      1000
`define ITF_FILT_MIN_MS   6'd1
`define ITF_FILT_MAX_MS   6'd50
`define ITF_FILT_RST_MS   6'd5
`define ITF_FILT_W        6
`define ITF_MAX_TERM      16
`define ITF_N_TERM        12
`define ITF_FUNC_W        7

// register byte offsets
`define ITF_OFF_FILT      12'h000
`define ITF_OFF_POL       12'h004
`define ITF_OFF_PERMIT    12'h008
`define ITF_OFF_MODE      12'h00c
`define ITF_OFF_LEVEL     12'h010
`define ITF_OFF_OUTA      12'h014
`define ITF_OFF_OUTB      12'h018
`define ITF_OFF_FUNC      12'h040

// field positions and reset values
`define ITF_FILT_HI_LSB   8
`define ITF_POL_RST       16'h0000
`define ITF_PERMIT_RST    16'h0000
`define ITF_MODE_RST      8'h00
`define ITF_FUNC_RST      7'h00
`define ITF_MODE_SLEEP    0
`define ITF_MODE_COMP     2
`define ITF_MODE_THERMO   3
`define ITF_MODE_PHOTO    4
`define ITF_MODE_POSTERM  5
`define ITF_MODE_SRVPULSE 6
`define ITF_MODE_SRVSW    7
`define ITF_SLEEP_BY_TERM 2'h2
`define ITF_PERMIT_START  0
`define ITF_PERMIT_RUN    8
`define ITF_PERMIT_TERM1  4'h1
`define ITF_PERMIT_TERM2  4'h2

// terminal function codes
`define ITF_FN_PID_SET    7'h1f
`define ITF_FN_PID_FB     7'h20
`define ITF_FN_PID_SLEEP  7'h21
`define ITF_FN_TRQ_MODE   7'h22
`define ITF_FN_MIN_TRQ    7'h23
`define ITF_FN_MAX_TRQ    7'h24
`define ITF_FN_EXT_PANEL  7'h28
`define ITF_FN_START      7'h2a
`define ITF_FN_RUN        7'h2b
`define ITF_FN_CNT_CLK    7'h2c
`define ITF_FN_CNT_TRIG   7'h2e
`define ITF_FN_CNT_RST    7'h30
`define ITF_FN_CNT_GATE   7'h32
`define ITF_FN_TMR_TRIG   7'h34
`define ITF_FN_TMR_RST    7'h37
`define ITF_FN_TMR_GATE   7'h3a
`define ITF_FN_PLEN_CLR   7'h3d
`define ITF_FN_THERMO     7'h3e
`define ITF_FN_COMP_SEL   7'h3f
`define ITF_FN_FLUX_BRK   7'h41
`define ITF_FN_POS_CLR    7'h42
`define ITF_FN_SRV_DIR    7'h44
`define ITF_FN_SRV_EN     7'h45
`define ITF_FN_ORIGIN     7'h46
`define ITF_FN_HOME       7'h47
`define ITF_FN_SPOS       7'h48

`endif

/* rtl/itf_pkg.sv */
`include "itf_params.svh"
package itf_pkg;

  typedef struct packed {
    logic       spindleHold;
    logic [2:0] spindlePos;
    logic       spindleHome;
    logic       spindleOrigin;
    logic       servoEnable;
    logic       servoDirDown;
    logic       posCntClr;
    logic       fluxBrake;
    logic [1:0] compGroup;
    logic       motorThermo;
    logic       pulseLenClr;
    logic [2:0] tmrGate;
    logic [2:0] tmrRst;
    logic [2:0] tmrTrig;
    logic [1:0] cntGate;
    logic [1:0] cntRst;
    logic [1:0] cntTrig;
    logic [1:0] cntClk;
    logic       runPermit;
    logic       startPermit;
    logic       extPanel;
    logic       maxTrqSel2;
    logic       minTrqSel2;
    logic       torqueMode;
    logic       pidSleep;
    logic       pidFbSel2;
    logic       pidSetSel2;
  } itf_out_t;

  typedef struct packed {
    logic                                                pready;
    logic                                                pslverr;
    logic [31:0]                                         prdata;
    logic [`ITF_FILT_W-1:0]                              filtLo;
    logic [`ITF_FILT_W-1:0]                              filtHi;
    logic [`ITF_MAX_TERM-1:0]                            pol;
    logic [15:0]                                         permit;
    logic [7:0]                                          mode;
    logic [`ITF_MAX_TERM-1:0][`ITF_FUNC_W-1:0]           func;
    itf_out_t                                            out;
  } itf_top_st_t;

  typedef struct packed {
    logic [`ITF_MAX_TERM-1:0]                            stable;
    logic [`ITF_MAX_TERM-1:0][`ITF_FILT_W-1:0]           cnt;
  } itf_filt_st_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } itf_tick_st_t;

endpackage

/* rtl/itf_filt_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "itf_params.svh"
interface itf_filt_if #(parameter int N = `ITF_N_TERM);
  logic                   msTick;
  logic [`ITF_FILT_W-1:0] timeLo;
  logic [`ITF_FILT_W-1:0] timeHi;
  logic [N-1:0]           level;
  modport ctrl (output msTick, output timeLo, output timeHi, input level);
  modport bank (input msTick, input timeLo, input timeHi, output level);
endinterface
`default_nettype wire

/* rtl/itf_ms_tick.sv */
`timescale 1ns/1ps
`default_nettype none
`include "itf_params.svh"
module itf_ms_tick import itf_pkg::*; #(
  parameter int CLK_PER_MS = `ITF_CLK_HZ / `ITF_MS_PER_S
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // one-cycle pulse every millisecond
  output logic      tick
);
  itf_tick_st_t st;
  itf_tick_st_t next_st;

  if (CLK_PER_MS < 1) begin : g_chk
    $error("CLK_PER_MS must be at least 1");
  end

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= 32'(CLK_PER_MS - 1)) begin
      next_st.cnt = 32'h0000_0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule
`default_nettype wire

/* rtl/itf_filter_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "itf_params.svh"
module itf_filter_bank import itf_pkg::*; #(
  parameter int N = `ITF_N_TERM
) (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // raw terminal levels, high while connected to common
  input  wire logic [N-1:0] din,
  // filter timing in, filtered levels out
  itf_filt_if.bank    f
);
  localparam int LO_TERMS = 5;

  itf_filt_st_t st;
  itf_filt_st_t next_st;
  logic [`ITF_MAX_TERM-1:0]                  nStable;
  logic [`ITF_MAX_TERM-1:0][`ITF_FILT_W-1:0] nCnt;

  if (N < 1 || N > `ITF_MAX_TERM) begin : g_chk
    $error("terminal count out of range");
  end

  // a change is taken only after it has held for the filter time
  for (genvar i = 0; i < `ITF_MAX_TERM; i++) begin : g_term
    logic [`ITF_FILT_W-1:0] lim;
    logic [`ITF_FILT_W-1:0] inc;
    logic                   raw;
    assign lim = (i < LO_TERMS) ? f.timeLo : f.timeHi;
    assign inc = st.cnt[i] + `ITF_FILT_W'(1);
    if (i < N) begin : g_in
      assign raw = din[i];
    end else begin : g_pad
      assign raw = 1'b0;
    end
    always_comb begin
      nStable[i] = st.stable[i];
      nCnt[i]    = st.cnt[i];
      if (raw == st.stable[i]) begin
        nCnt[i] = '0;
      end else if (f.msTick) begin
        // the first tick may fall just after the change, so one more is needed
        if (inc > lim) begin
          nStable[i] = raw;
          nCnt[i]    = '0;
        end else begin
          nCnt[i] = inc;
        end
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.stable = nStable;
    next_st.cnt    = nCnt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign f.level = st.stable[N-1:0];
endmodule
`default_nettype wire

/* rtl/itf_top.sv */
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "itf_params.svh"
// Functional notes
// - function 31 picks process setpoint source two
// - function 32 picks process feedback source two
// - function 33 sleeps only when source selects terminal
// - function 34 selects torque mode, else speed
// - function 35 selects second minimum torque limit
// - function 36 selects second maximum torque limit
// - function 40 gives commands to external panel
// - start permit counts only if digit0 1/2
// - run permit counts only if digit2 1/2
// - functions 44..51 drive counter clock/trigger/reset/gate
// - functions 52..60 drive timer trigger/reset/gate
// - function 61 clears single pulse length
// - function 62 is thermo contact when configured
// - functions 63/64 pick compensation parameter group
// - function 65 enables flux braking on deceleration
// - function 66 clears position pulse count
// - function 68 sets servo pulse count direction
// - function 69 switches servo and torque control
// - function 70 is origin when photoelectric selected
// - function 71 homes spindle and holds torque
// - functions 72..74 select stored spindle angle
// - level change accepted after filter time only
// - polarity bit per terminal inverts active sense
module itf_top import itf_pkg::*; #(
  parameter int N          = `ITF_N_TERM,
  parameter int CLK_PER_MS = `ITF_CLK_HZ / `ITF_MS_PER_S
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // terminals, high while connected to common
  input  wire logic [N-1:0] din,
  // process pid and torque selections
  output logic             pidSetSel2,
  output logic             pidFbSel2,
  output logic             pidSleep,
  output logic             torqueMode,
  output logic             minTrqSel2,
  output logic             maxTrqSel2,
  // command source and permits
  output logic             extPanel,
  output logic             startPermit,
  output logic             runPermit,
  // counters and timers
  output logic      [1:0]  cntClk,
  output logic      [1:0]  cntTrig,
  output logic      [1:0]  cntRst,
  output logic      [1:0]  cntGate,
  output logic      [2:0]  tmrTrig,
  output logic      [2:0]  tmrRst,
  output logic      [2:0]  tmrGate,
  // motor, compensation and position
  output logic             pulseLenClr,
  output logic             motorThermo,
  output logic      [1:0]  compGroup,
  output logic             fluxBrake,
  output logic             posCntClr,
  output logic             servoDirDown,
  output logic             servoEnable,
  // spindle
  output logic             spindleOrigin,
  output logic             spindleHome,
  output logic      [2:0]  spindlePos,
  output logic             spindleHold
);
  localparam int NCODE = 1 << `ITF_FUNC_W;

  itf_top_st_t st;
  itf_top_st_t next_st;
  logic        msTick;
  logic [N-1:0] active;
  logic [NCODE-1:0] act;
  logic [39:0] outBits;
  itf_out_t    o;
  logic        sleepOn;
  logic        compOn;
  logic        thermoOn;
  logic        photoOn;
  logic        posOn;
  logic        pulseOn;
  logic        servoOn;
  logic [N-1:0][NCODE-1:0] hot;

  if (N < 1 || N > `ITF_MAX_TERM) begin : g_chk
    $error("terminal count out of range");
  end

  if (CLK_PER_MS < 1) begin : g_chk_ms
    $error("clock cycles per millisecond must be at least 1");
  end

  itf_filt_if #(.N(N)) filt ();

  itf_ms_tick #(.CLK_PER_MS(CLK_PER_MS)) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (msTick)
  );

  itf_filter_bank #(.N(N)) u_filt (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (din),
    .f     (filt.bank)
  );

  assign filt.msTick = msTick;
  assign filt.timeLo = st.filtLo;
  assign filt.timeHi = st.filtHi;

  // polarity bit one makes an open terminal the active one
  for (genvar t = 0; t < N; t++) begin : g_pol
    assign active[t] = filt.level[t] ^ st.pol[t];
  end
  assign outBits = st.out;

  // configuration bits that hand a function over to the terminals
  assign sleepOn  = st.mode[`ITF_MODE_SLEEP +: 2] == `ITF_SLEEP_BY_TERM;
  assign compOn   = st.mode[`ITF_MODE_COMP];
  assign thermoOn = st.mode[`ITF_MODE_THERMO];
  assign photoOn  = st.mode[`ITF_MODE_PHOTO];
  assign posOn    = st.mode[`ITF_MODE_POSTERM];
  assign pulseOn  = st.mode[`ITF_MODE_SRVPULSE];
  assign servoOn  = st.mode[`ITF_MODE_SRVSW];

  // clamp a filter time into its legal range
  function automatic logic [`ITF_FILT_W-1:0] clampTime(input logic [`ITF_FILT_W-1:0] v);
    logic [`ITF_FILT_W-1:0] r;
    r = v;
    if (v < `ITF_FILT_MIN_MS) begin
      r = `ITF_FILT_MIN_MS;
    end else if (v > `ITF_FILT_MAX_MS) begin
      r = `ITF_FILT_MAX_MS;
    end
    return r;
  endfunction

  // a permit digit hands control to the terminal when it is 1 or 2
  function automatic logic permitByTerm(input logic [3:0] d);
    return (d == `ITF_PERMIT_TERM1) || (d == `ITF_PERMIT_TERM2);
  endfunction

  // each terminal feeds only the function code assigned to it
  for (genvar t = 0; t < N; t++) begin : g_hot
    assign hot[t] = active[t] ? (NCODE'(1) << st.func[t]) : NCODE'(0);
  end

  // terminals that share a code are ored together
  always_comb begin
    act = '0;
    for (int t = 0; t < N; t++) begin
      act = act | hot[t];
    end
  end

  // function decode
  always_comb begin
    logic [2:0] pos;
    o = '0;
    pos = '0;
    o.pidSetSel2 = act[`ITF_FN_PID_SET];
    o.pidFbSel2  = act[`ITF_FN_PID_FB];
    o.pidSleep   = sleepOn && act[`ITF_FN_PID_SLEEP];
    o.torqueMode = act[`ITF_FN_TRQ_MODE];
    o.minTrqSel2 = act[`ITF_FN_MIN_TRQ];
    o.maxTrqSel2 = act[`ITF_FN_MAX_TRQ];
    o.extPanel   = act[`ITF_FN_EXT_PANEL];
    // a permit that is not terminal-controlled never blocks
    o.startPermit = permitByTerm(st.permit[`ITF_PERMIT_START +: 4])
                    ? act[`ITF_FN_START] : 1'b1;
    o.runPermit   = permitByTerm(st.permit[`ITF_PERMIT_RUN +: 4])
                    ? act[`ITF_FN_RUN] : 1'b1;
    for (int k = 0; k < 2; k++) begin
      o.cntClk[k]  = act[`ITF_FN_CNT_CLK + 7'(k)];
      o.cntTrig[k] = act[`ITF_FN_CNT_TRIG + 7'(k)];
      o.cntRst[k]  = act[`ITF_FN_CNT_RST + 7'(k)];
      o.cntGate[k] = act[`ITF_FN_CNT_GATE + 7'(k)];
    end
    for (int k = 0; k < 3; k++) begin
      o.tmrTrig[k] = act[`ITF_FN_TMR_TRIG + 7'(k)];
      o.tmrRst[k]  = act[`ITF_FN_TMR_RST + 7'(k)];
      o.tmrGate[k] = act[`ITF_FN_TMR_GATE + 7'(k)];
    end
    o.pulseLenClr = act[`ITF_FN_PLEN_CLR];
    o.motorThermo = thermoOn && act[`ITF_FN_THERMO];
    // group 0 is used whenever terminal selection is off
    if (compOn) begin
      o.compGroup = {act[`ITF_FN_COMP_SEL + 7'd1], act[`ITF_FN_COMP_SEL]};
    end
    o.fluxBrake    = act[`ITF_FN_FLUX_BRK];
    o.posCntClr    = act[`ITF_FN_POS_CLR];
    o.servoDirDown = pulseOn && act[`ITF_FN_SRV_DIR];
    o.servoEnable  = servoOn && act[`ITF_FN_SRV_EN];
    o.spindleOrigin = photoOn && act[`ITF_FN_ORIGIN];
    o.spindleHome   = act[`ITF_FN_HOME];
    if (posOn) begin
      pos = {act[`ITF_FN_SPOS + 7'd2], act[`ITF_FN_SPOS + 7'd1], act[`ITF_FN_SPOS]};
    end
    o.spindlePos = pos;
    // torque is held while homing or at a selected angle, dropped otherwise
    o.spindleHold = o.spindleHome || (pos != 3'h0);
  end

  // register file and apb slave, one access cycle after setup
  always_comb begin
    logic        setup;
    logic        wr;
    logic [11:0] fOff;
    logic [3:0]  fIdx;
    logic        fHit;
    next_st = st;
    setup = psel && !penable;
    // a write lands only in the access cycle of an accepted setup
    wr    = psel && penable && st.pready && pwrite;
    fOff  = paddr - `ITF_OFF_FUNC;
    fIdx  = fOff[5:2];
    fHit  = (paddr >= `ITF_OFF_FUNC) && (fOff[11:2] < 10'(N)) && (paddr[1:0] == 2'b00);
    next_st.pready  = setup;
    next_st.out     = o;
    if (setup) begin
      next_st.prdata  = 32'h0000_0000;
      next_st.pslverr = 1'b0;
      case (paddr)
        `ITF_OFF_FILT: begin
          next_st.prdata[`ITF_FILT_W-1:0] = st.filtLo;
          next_st.prdata[`ITF_FILT_HI_LSB +: `ITF_FILT_W] = st.filtHi;
        end
        `ITF_OFF_POL: begin
          next_st.prdata[N-1:0] = st.pol[N-1:0];
        end
        `ITF_OFF_PERMIT: begin
          next_st.prdata[15:0] = st.permit;
        end
        `ITF_OFF_MODE: begin
          next_st.prdata[7:0] = st.mode;
        end
        `ITF_OFF_LEVEL: begin
          next_st.prdata[N-1:0] = active;
        end
        `ITF_OFF_OUTA: begin
          next_st.prdata = outBits[31:0];
        end
        `ITF_OFF_OUTB: begin
          next_st.prdata[7:0] = outBits[39:32];
        end
        default: begin
          if (fHit) begin
            next_st.prdata[`ITF_FUNC_W-1:0] = st.func[fIdx];
          end else begin
            next_st.pslverr = 1'b1;
          end
        end
      endcase
    end else begin
      // read data and error stand only in the access cycle
      next_st.prdata  = 32'h0000_0000;
      next_st.pslverr = 1'b0;
    end
    if (wr && !st.pslverr) begin
      case (paddr)
        `ITF_OFF_FILT: begin
          next_st.filtLo = clampTime(pwdata[`ITF_FILT_W-1:0]);
          next_st.filtHi = clampTime(pwdata[`ITF_FILT_HI_LSB +: `ITF_FILT_W]);
        end
        `ITF_OFF_POL: begin
          next_st.pol = '0;
          next_st.pol[N-1:0] = pwdata[N-1:0];
        end
        `ITF_OFF_PERMIT: begin
          next_st.permit = pwdata[15:0];
        end
        `ITF_OFF_MODE: begin
          next_st.mode = pwdata[7:0];
        end
        default: begin
          if (fHit) begin
            next_st.func[fIdx] = pwdata[`ITF_FUNC_W-1:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.filtLo <= `ITF_FILT_RST_MS;
      st.filtHi <= `ITF_FILT_RST_MS;
      st.pol    <= `ITF_POL_RST;
      st.permit <= `ITF_PERMIT_RST;
      st.mode   <= `ITF_MODE_RST;
      // no terminal controls the permits yet, so they start released
      st.out.startPermit <= 1'b1;
      st.out.runPermit   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign pidSetSel2    = st.out.pidSetSel2;
  assign pidFbSel2     = st.out.pidFbSel2;
  assign pidSleep      = st.out.pidSleep;
  assign torqueMode    = st.out.torqueMode;
  assign minTrqSel2    = st.out.minTrqSel2;
  assign maxTrqSel2    = st.out.maxTrqSel2;
  assign extPanel      = st.out.extPanel;
  assign startPermit   = st.out.startPermit;
  assign runPermit     = st.out.runPermit;
  assign cntClk        = st.out.cntClk;
  assign cntTrig       = st.out.cntTrig;
  assign cntRst        = st.out.cntRst;
  assign cntGate       = st.out.cntGate;
  assign tmrTrig       = st.out.tmrTrig;
  assign tmrRst        = st.out.tmrRst;
  assign tmrGate       = st.out.tmrGate;
  assign pulseLenClr   = st.out.pulseLenClr;
  assign motorThermo   = st.out.motorThermo;
  assign compGroup     = st.out.compGroup;
  assign fluxBrake     = st.out.fluxBrake;
  assign posCntClr     = st.out.posCntClr;
  assign servoDirDown  = st.out.servoDirDown;
  assign servoEnable   = st.out.servoEnable;
  assign spindleOrigin = st.out.spindleOrigin;
  assign spindleHome   = st.out.spindleHome;
  assign spindlePos    = st.out.spindlePos;
  assign spindleHold   = st.out.spindleHold;
endmodule
`default_nettype wire

/* tb/itf_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module itf_top_monitor (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // function outputs
  input  wire logic        startPermit,
  input  wire logic        runPermit,
  input  wire logic        spindleHome,
  input  wire logic [2:0]  spindlePos,
  input  wire logic        spindleHold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence setupS;
    psel && !penable;
  endsequence
  sequence answerS;
    pready ##1 !pready;
  endsequence
  AST_RDY_ANSWER: assert property (setupS |=> answerS)
    else $error("pready did not pulse once after setup");
  AST_RDY_CAUSE: assert property (pready |-> $past(psel && !penable))
    else $error("pready without a preceding setup");
  AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_ODD: assert property (setupS ##0 (paddr[1:0] != 2'h0) |=> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  AST_ERR_MAPPED: assert property (setupS ##0 (paddr == 12'h000) |=> !pslverr)
    else $error("mapped access refused");
  AST_HOLD: assert property (spindleHold == (spindleHome || spindlePos != 3'h0))
    else $error("spindle hold does not follow home or position");
  AST_RST_PERMIT: assert property ($rose(rst_n) |-> startPermit && runPermit)
    else $error("permits not released after reset");
endmodule
bind itf_top itf_top_monitor itf_top_monitor_inst (.clk, .rst_n, .paddr, .psel, .penable,
  .prdata, .pready, .pslverr, .startPermit, .runPermit, .spindleHome, .spindlePos, .spindleHold);
`default_nettype wire

/* tb/itf_switch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module itf_switch_model #(
  parameter int N = 12
) (
  // clock
  input  wire logic         clk,
  // wanted contact state
  input  wire logic [N-1:0] want,
  // contacts as seen by the block
  output logic      [N-1:0] din
);
  logic [N-1:0] w1;
  logic [N-1:0] w2;
  initial begin
    w1 = '0;
    w2 = '0;
    din = '0;
  end
  // every change bounces back for one cycle before it settles
  always @(posedge clk) begin
    w1 <= want;
    w2 <= w1;
    din <= want ^ ((w1 ^ w2) & ~(want ^ w1));
  end
endmodule
`default_nettype wire

/* tb/itf_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "itf_params.svh"
module itf_top_tb;
  typedef struct packed {
    logic [31:0] d;
    logic        e;
    logic        c;
  } itf_exp_t;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] want;
  logic [11:0] din;
  logic [39:0] v;
  wire  [39:0] pins;
  logic        pol;
  itf_exp_t    cur;
  itf_exp_t    expQ[$];
  int          failures;
  int          compares;
  int          seed;
  int          r;

  itf_top #(.N(12), .CLK_PER_MS(4)) itf_top_inst (
    .clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .din,
    .pidSetSel2(pins[0]), .pidFbSel2(pins[1]), .pidSleep(pins[2]), .torqueMode(pins[3]),
    .minTrqSel2(pins[4]), .maxTrqSel2(pins[5]), .extPanel(pins[6]), .startPermit(pins[7]),
    .runPermit(pins[8]), .cntClk(pins[10:9]), .cntTrig(pins[12:11]), .cntRst(pins[14:13]),
    .cntGate(pins[16:15]), .tmrTrig(pins[19:17]), .tmrRst(pins[22:20]), .tmrGate(pins[25:23]),
    .pulseLenClr(pins[26]), .motorThermo(pins[27]), .compGroup(pins[29:28]),
    .fluxBrake(pins[30]), .posCntClr(pins[31]), .servoDirDown(pins[32]),
    .servoEnable(pins[33]), .spindleOrigin(pins[34]), .spindleHome(pins[35]),
    .spindlePos(pins[38:36]), .spindleHold(pins[39])
  );
  itf_switch_model #(.N(12)) itf_switch_model_inst (.clk, .want, .din);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    if (expQ.size() != 0) failures++;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee, input logic ce);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    expQ.push_back('{ed, ee, ce});
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("[FAIL] t=%0t pready %h exp %h", $time, pready, 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d, 32'h0, ee, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic ee);
    apb(1'b0, a, 32'h0, ed, ee, 1'b1);
  endtask

  // expected output word: code c, terminal active act, gating modes on
  function automatic logic [39:0] expOut(input int c, input logic act, input logic on);
    logic [39:0] e;
    e = 40'h0;
    if (c >= 31 && c <= 36) e[c-31] = 1'b1;
    else if (c == 40) e[6] = 1'b1;
    else if (c >= 42 && c <= 66) e[c-35] = 1'b1;
    else if (c >= 68 && c <= 74) e[c-36] = 1'b1;
    if (c >= 71 && c <= 74) e[39] = 1'b1;
    if (!act || (!on && c inside {33, 62, 63, 64, 68, 69, 70, 72, 73, 74})) e = 40'h0;
    if (!on) e[8:7] = 2'b11;
    return e;
  endfunction

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && expQ.size() > 0) begin
      cur = expQ.pop_front();
      compares++;
      if (pslverr !== cur.e || (cur.c && prdata !== cur.d)) begin
        failures++;
        $display("[FAIL] t=%0t got %h/%h exp %h/%h", $time, prdata, pslverr, cur.d, cur.e);
      end
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    seed = 32'h2746;
    failures = 0;
    compares = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    want = 12'h0;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ITF_OFF_FILT, 32'h0505, 1'b0);
    rd(`ITF_OFF_POL, 32'h0, 1'b0);
    rd(`ITF_OFF_OUTA, 32'h180, 1'b0);
    rd(`ITF_OFF_FUNC, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    rd(12'h002, 32'h0, 1'b1);
    wr(12'h020, 32'hffff, 1'b1);
    wr(`ITF_OFF_LEVEL, 32'hfff, 1'b0);
    rd(`ITF_OFF_LEVEL, 32'h0, 1'b0);
    wr(`ITF_OFF_FILT, 32'h3f00, 1'b0);
    rd(`ITF_OFF_FILT, 32'h3201, 1'b0);
    $display("test registers done");
    // pass 0 enables every gated function, pass 1 disables them
    for (int p = 0; p < 2; p++) begin
      wr(`ITF_OFF_MODE, (p == 0) ? 32'hfe : 32'h0, 1'b0);
      wr(`ITF_OFF_PERMIT, (p == 0) ? 32'h0101 : 32'h0303, 1'b0);
      for (int c = 31; c <= 74; c++) begin
        r = $random(seed);
        pol = r[0];
        wr(`ITF_OFF_POL, {31'h0, pol}, 1'b0);
        wr(`ITF_OFF_FUNC, c, 1'b0);
        for (int k = 0; k < 2; k++) begin
          r = $random(seed);
          want <= {r[10:0], pol ^ k[0]};
          repeat (12) @(posedge clk);
          v = expOut(c, k[0], p == 0);
          rd(`ITF_OFF_OUTA, v[31:0], 1'b0);
          rd(`ITF_OFF_OUTB, {24'h0, v[39:32]}, 1'b0);
          compares++;
          if (pins !== v) begin
            failures++;
            $display("[FAIL] t=%0t pins %h exp %h", $time, pins, v);
          end
        end
      end
      $display("test function pass %0d done", p);
    end
    wr(`ITF_OFF_FILT, 32'h0503, 1'b0);
    wr(`ITF_OFF_POL, 32'h0, 1'b0);
    wr(`ITF_OFF_FUNC, 32'd31, 1'b0);
    want <= 12'h0;
    repeat (12) @(posedge clk);
    want <= 12'h001;
    repeat (4) @(posedge clk);
    want <= 12'h000;
    repeat (20) @(posedge clk);
    rd(`ITF_OFF_LEVEL, 32'h0, 1'b0);
    want <= 12'h001;
    repeat (5) @(posedge clk);
    rd(`ITF_OFF_LEVEL, 32'h0, 1'b0);
    repeat (12) @(posedge clk);
    rd(`ITF_OFF_LEVEL, 32'h1, 1'b0);
    rd(`ITF_OFF_OUTA, 32'h181, 1'b0);
    $display("test filter done");
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
